// ### core/adcsr_defs.svh
// Timing counts, frame layout and field positions shared by both link ends.
// Assumes a 100 MHz REF_CLK on both ends; counts below are derived from it.
`ifndef ADCSR_DEFS_SVH
`define ADCSR_DEFS_SVH

// Frame and configuration word layout
`define ADCSR_FRAME_BITS 6'd32
`define ADCSR_CFG_BITS 6'd13
`define ADCSR_CFG_DBL_BIT 0
`define ADCSR_ABORT_MIN_FALL 6'd5
`define ADCSR_CFG_COMMIT_FALL 6'd14

// Timing
`define ADCSR_CLK_NS 10
`define ADCSR_TEST_DELAY_NS 500
`define ADCSR_TEST_CYC 16'((`ADCSR_TEST_DELAY_NS + `ADCSR_CLK_NS - 1) / `ADCSR_CLK_NS)
`define ADCSR_SCK_HALF 16'd8
`define ADCSR_CONV_CYC 16'd300
`define ADCSR_GAP_CYC 16'd16

// Reset values
`define ADCSR_CFG_RST 13'h0000

// Receive buffer
`define ADCSR_FIFO_DEPTH 8
`define ADCSR_FIFO_WIDTH 32

`endif

// ### core/adcsr_pkg.sv
// Types shared by the two ends of the serial readout link.
// Assumes adcsr_defs.svh is on the include path.
`include "adcsr_defs.svh"
package adcsr_pkg;

    typedef enum logic [3:0] {
        DST_CONV = 4'b0001,
        DST_SLEEP = 4'b0010,
        DST_TEST = 4'b0100,
        DST_SHIFT = 4'b1000
    } adcsr_dst_e;

    typedef enum logic [2:0] {
        HST_IDLE = 3'b001,
        HST_SHIFT = 3'b010,
        HST_GAP = 3'b100
    } adcsr_hst_e;

    typedef struct packed {
        adcsr_dst_e st;
        logic cs_s1, cs_s2, cs_p;
        logic sck_s1, sck_s2, sck_p;
        logic sdi_s1, sdi_s2;
        logic strap_s1, strap_s2;
        logic sdo, sdo_oe, sck_o, sck_oe, busy, mux_sw;
        logic [31:0] shreg;
        logic [12:0] din;
        logic [12:0] cfg;
        logic [5:0] rises;
        logic [5:0] falls;
        logic [15:0] cnt;
    } adcsr_dev_s;

    typedef struct packed {
        adcsr_hst_e st;
        logic sck_s1, sck_s2, sck_p;
        logic sdo_s1, sdo_s2;
        logic busy_s1, busy_s2;
        logic cs_n, sck, sck_oe, sdi, strap_n, push;
        logic [31:0] rx;
        logic [12:0] tx;
        logic [5:0] bits;
        logic [15:0] cnt;
    } adcsr_host_s;

endpackage : adcsr_pkg

// ### core/adcsr_if.sv
// Serial link between converter end and host end, with pin resolution.
// Assumes both ends drive only output enables; undriven lines pull high.
interface adcsr_if;
    logic cs_n;       // Chip select, host drives
    logic sck_h;      // Serial clock driven by host
    logic sck_h_oe;   // Host drives serial clock
    logic sck_d;      // Serial clock driven by converter
    logic sck_d_oe;   // Converter drives serial clock
    logic sck;        // Resolved serial clock line
    logic sdi;        // Configuration data to converter
    logic sdo;        // Converter data output value
    logic sdo_oe;     // Converter drives data output
    logic sdo_line;   // Resolved data output line
    logic busy;       // Converter busy output
    logic clock_source_strap_n; // Low: host makes serial clock

    // Pull-ups model the idle level of an undriven line
    assign sck = sck_d_oe ? sck_d : (sck_h_oe ? sck_h : 1'b1);
    assign sdo_line = sdo_oe ? sdo : 1'b1;

    modport dev (
        input cs_n, sck, sdi, clock_source_strap_n,
        output sck_d, sck_d_oe, sdo, sdo_oe, busy
    );
    modport host (
        input sck, sdo_line, busy,
        output cs_n, sck_h, sck_h_oe, sdi, clock_source_strap_n
    );
endinterface : adcsr_if

// ### core/adcsr_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock; DEPTH is a power of two.
`include "adcsr_defs.svh"
module adcsr_fifo #(
    parameter int WIDTH = `ADCSR_FIFO_WIDTH,
    parameter int DEPTH = `ADCSR_FIFO_DEPTH
) (
    input wire logic clk,                 // Clock
    input wire logic srst,                // Synchronous reset, high
    input wire logic in_valid,            // Write request
    output logic in_ready,                // Space available
    input wire logic [WIDTH-1:0] in_data, // Write data
    output logic out_valid,               // Data available
    input wire logic out_ready,           // Read accept
    output logic [WIDTH-1:0] out_data     // Head word
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW:0] wp;
        logic [AW:0] rp;
    } adcsr_fifo_s;

    adcsr_fifo_s r, n;
    logic full, empty;

    ////////////////////////////////////////////////////////////////////////
    // Full when pointers differ only in the wrap bit
    assign full = (r.wp[AW] != r.rp[AW]) && (r.wp[AW-1:0] == r.rp[AW-1:0]);
    assign empty = (r.wp == r.rp);
    assign in_ready = ~full;
    assign out_valid = ~empty;
    assign out_data = r.mem[r.rp[AW-1:0]];

    // Pointer and storage update
    always_comb begin
        n = r;
        if (in_valid && !full) begin
            n.mem[r.wp[AW-1:0]] = in_data;
            n.wp = r.wp + 1'b1;
        end
        if (out_ready && !empty) begin
            n.rp = r.rp + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end
endmodule : adcsr_fifo

// ### core/adcsr_dev.sv
// Converter end: conversion cycle, sleep, status test and 32-bit serial readout.
// Assumes link pins arrive asynchronously and are synchronised here; the
// conversion itself is modelled by a fixed count and a result word from user logic.
//
// Notes on behaviour
// - Strap low selects host serial clock
// - Data output floats while select high
// - Select low shows inverted end status
// - Enter sleep after conversion on own
// - Sleep holds result until first clock rise
// - Shift out on fall, capture on rise
// - Thirty-two bit frame, status bit first
// - External clock: 32nd fall starts conversion
// - External clock: select rise aborts after fifth
// - Abort before 13th rise keeps configuration
// - Host holds select past 14th fall
// - Load result when end status falls
// - Strap high selects device serial clock
// - Internal clock: select fall drives clock low
// - Internal clock: readout 500ns after ready
// - Select rise during test keeps sleeping
// - Internal clock: after 32nd rise, convert
// - Internal clock: select rise aborts readout
// - Busy high converting, low until read
// - Continuous: clock high converting, auto readout
// - Host watches status or busy afterwards
// - Busy rises when readout cycle ends
// - Normal rate: switch input at 14th fall
`include "adcsr_defs.svh"
module adcsr_dev (
    input wire logic REF_CLK,       // 100 MHz clock
    input wire logic SRST,          // Synchronous reset, high
    adcsr_if.dev LINK,              // Serial link pins
    input wire logic [30:0] RESULT, // Conversion result from user logic
    output logic [12:0] CFG,        // Stored configuration word
    output logic MUX_SWITCH,        // Pulse: input multiplexer switches
    output logic CONVERTING         // Conversion in progress
);
    adcsr_pkg::adcsr_dev_s r, n;
    logic cs_rise, cs_fall, sck_rise, sck_fall, ext_mode, half_tick;

    ////////////////////////////////////////////////////////////////////////
    // Outputs, all straight from the state register
    assign LINK.sdo = r.sdo;
    assign LINK.sdo_oe = r.sdo_oe;
    assign LINK.sck_d = r.sck_o;
    assign LINK.sck_d_oe = r.sck_oe;
    assign LINK.busy = r.busy;
    assign CFG = r.cfg;
    assign MUX_SWITCH = r.mux_sw;
    assign CONVERTING = r.busy;

    // Edge detection looks only at the second synchroniser stage and its delay
    assign cs_rise = r.cs_s2 & ~r.cs_p;
    assign cs_fall = ~r.cs_s2 & r.cs_p;
    assign sck_rise = r.sck_s2 & ~r.sck_p;
    assign sck_fall = ~r.sck_s2 & r.sck_p;
    assign ext_mode = ~r.strap_s2;
    assign half_tick = (r.cnt == `ADCSR_SCK_HALF - 16'd1);

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        n = r;
        n.mux_sw = 1'b0;
        // Two-stage synchronisers for every pin from the far end
        n.cs_s1 = LINK.cs_n;
        n.cs_s2 = r.cs_s1;
        n.cs_p = r.cs_s2;
        n.sck_s1 = LINK.sck;
        n.sck_s2 = r.sck_s1;
        n.sck_p = r.sck_s2;
        n.sdi_s1 = LINK.sdi;
        n.sdi_s2 = r.sdi_s1;
        n.strap_s1 = LINK.clock_source_strap_n;
        n.strap_s2 = r.strap_s1;
        // Pin drivers follow the synchronised select and strap
        n.sdo_oe = ~r.cs_s2;
        n.sck_oe = ~ext_mode;

        case (r.st)
            adcsr_pkg::DST_CONV: begin
                n.busy = 1'b1;
                n.sdo = 1'b1;
                if (!ext_mode && cs_fall) begin
                    n.sck_o = 1'b0;
                end
                if (r.cnt == `ADCSR_CONV_CYC - 16'd1) begin
                    // Conversion done: load result, drop status and busy
                    n.cnt = 16'd0;
                    n.shreg = {1'b0, RESULT};
                    n.sdo = 1'b0;
                    n.busy = 1'b0;
                    n.rises = 6'd0;
                    n.falls = 6'd0;
                    if (r.cfg[`ADCSR_CFG_DBL_BIT]) begin
                        n.mux_sw = 1'b1; // Double rate switches at end of conversion
                    end
                    if (!ext_mode) begin
                        n.sck_o = 1'b0;
                        // Select already low: status test starts now
                        n.st = r.cs_s2 ? adcsr_pkg::DST_SLEEP : adcsr_pkg::DST_TEST;
                    end else begin
                        n.st = adcsr_pkg::DST_SLEEP;
                    end
                end else begin
                    n.cnt = r.cnt + 16'd1;
                end
            end

            adcsr_pkg::DST_SLEEP: begin
                // Result held static in the shift register
                n.busy = 1'b0;
                n.sdo = r.shreg[31];
                if (ext_mode) begin
                    if (sck_rise) begin
                        // First rise leaves sleep and captures the first input bit
                        n.din = {r.din[11:0], r.sdi_s2};
                        n.rises = 6'd1;
                        n.st = adcsr_pkg::DST_SHIFT;
                    end
                end else if (!r.cs_s2) begin
                    n.sck_o = 1'b0;
                    n.cnt = 16'd0;
                    n.st = adcsr_pkg::DST_TEST;
                end
            end

            adcsr_pkg::DST_TEST: begin
                // Internal clock only: status test interval before output starts
                n.busy = 1'b0;
                n.sdo = r.shreg[31];
                if (r.cs_s2 || ext_mode) begin
                    n.cnt = 16'd0;
                    n.st = adcsr_pkg::DST_SLEEP;
                end else if (r.cnt == `ADCSR_TEST_CYC - 16'd1) begin
                    n.cnt = 16'd0;
                    n.sck_o = 1'b1;
                    n.din = {r.din[11:0], r.sdi_s2};
                    n.rises = 6'd1;
                    n.st = adcsr_pkg::DST_SHIFT;
                end else begin
                    n.cnt = r.cnt + 16'd1;
                end
            end

            adcsr_pkg::DST_SHIFT: begin
                n.busy = 1'b0;
                if (ext_mode) begin
                    if (cs_rise && r.falls >= `ADCSR_ABORT_MIN_FALL) begin
                        // Abort: new conversion at once, uncommitted input dropped
                        n.st = adcsr_pkg::DST_CONV;
                        n.cnt = 16'd0;
                        n.busy = 1'b1;
                        n.sdo = 1'b1;
                    end else if (sck_rise) begin
                        if (r.rises < `ADCSR_CFG_BITS) begin
                            n.din = {r.din[11:0], r.sdi_s2};
                        end
                        n.rises = r.rises + 6'd1;
                    end else if (sck_fall) begin
                        n.falls = r.falls + 6'd1;
                        n.shreg = {r.shreg[30:0], 1'b0};
                        n.sdo = r.shreg[30];
                        if (r.falls + 6'd1 == `ADCSR_CFG_COMMIT_FALL && r.rises >= `ADCSR_CFG_BITS) begin
                            n.cfg = r.din;
                            n.mux_sw = ~r.din[`ADCSR_CFG_DBL_BIT];
                        end
                        if (r.falls + 6'd1 == `ADCSR_FRAME_BITS) begin
                            n.st = adcsr_pkg::DST_CONV;
                            n.cnt = 16'd0;
                            n.busy = 1'b1;
                            n.sdo = 1'b1;
                        end
                    end
                end else begin
                    if (cs_rise) begin
                        // Any select rise after the first clock rise aborts
                        n.st = adcsr_pkg::DST_CONV;
                        n.cnt = 16'd0;
                        n.busy = 1'b1;
                        n.sdo = 1'b1;
                        n.sck_o = 1'b1;
                    end else if (half_tick) begin
                        n.cnt = 16'd0;
                        if (r.sck_o && r.rises == `ADCSR_FRAME_BITS) begin
                            // Half a period after the last rise: clock stays high
                            n.st = adcsr_pkg::DST_CONV;
                            n.busy = 1'b1;
                            n.sdo = 1'b1;
                        end else if (r.sck_o) begin
                            n.sck_o = 1'b0;
                            n.falls = r.falls + 6'd1;
                            n.shreg = {r.shreg[30:0], 1'b0};
                            n.sdo = r.shreg[30];
                            if (r.falls + 6'd1 == `ADCSR_CFG_COMMIT_FALL && r.rises >= `ADCSR_CFG_BITS) begin
                                n.cfg = r.din;
                                n.mux_sw = ~r.din[`ADCSR_CFG_DBL_BIT];
                            end
                        end else begin
                            n.sck_o = 1'b1;
                            if (r.rises < `ADCSR_CFG_BITS) begin
                                n.din = {r.din[11:0], r.sdi_s2};
                            end
                            n.rises = r.rises + 6'd1;
                        end
                    end else begin
                        n.cnt = r.cnt + 16'd1;
                    end
                end
            end

            default: begin
                n.st = adcsr_pkg::DST_CONV;
                n.cnt = 16'd0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // State register; a conversion starts straight after reset
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            r <= '0;
            r.st <= adcsr_pkg::DST_CONV;
            r.cs_s1 <= 1'b1;
            r.cs_s2 <= 1'b1;
            r.cs_p <= 1'b1;
            r.sdo <= 1'b1;
            r.sck_o <= 1'b1;
            r.busy <= 1'b1;
            r.cfg <= `ADCSR_CFG_RST;
        end else begin
            r <= n;
        end
    end
endmodule : adcsr_dev

// ### core/adcsr_host.sv
// Host end: reads 32-bit frames and sends the 13-bit configuration word.
// Assumes the converter end on the far side of the link; received frames
// are queued in a FIFO and no frame starts unless the FIFO has room.
`include "adcsr_defs.svh"
module adcsr_host (
    input wire logic REF_CLK,        // 100 MHz clock
    input wire logic SRST,           // Synchronous reset, high
    adcsr_if.host LINK,              // Serial link pins
    input wire logic INT_CLK_MODE,   // 1: converter makes serial clock
    input wire logic ENABLE,         // Allow readout frames
    input wire logic [12:0] CFG_WORD,// Configuration sent each frame
    output logic [31:0] RD_DATA,     // Received frame
    output logic RD_VALID,           // Frame available
    input wire logic RD_READY        // Frame taken
);
    adcsr_pkg::adcsr_host_s r, n;
    logic fifo_ready, sck_rise, sck_fall, phase_hi, phase_end;

    ////////////////////////////////////////////////////////////////////////
    // Pin outputs from the state register
    assign LINK.cs_n = r.cs_n;
    assign LINK.sck_h = r.sck;
    assign LINK.sck_h_oe = r.sck_oe;
    assign LINK.sdi = r.sdi;
    assign LINK.clock_source_strap_n = r.strap_n;

    assign sck_rise = r.sck_s2 & ~r.sck_p;
    assign sck_fall = ~r.sck_s2 & r.sck_p;
    assign phase_hi = (r.cnt == `ADCSR_SCK_HALF - 16'd1);
    assign phase_end = (r.cnt == 16'd2 * `ADCSR_SCK_HALF - 16'd1);

    // Frame queue; a full queue holds off the next frame
    adcsr_fifo #(.WIDTH(`ADCSR_FIFO_WIDTH), .DEPTH(`ADCSR_FIFO_DEPTH)) u_fifo (
        .clk(REF_CLK),
        .srst(SRST),
        .in_valid(r.push),
        .in_ready(fifo_ready),
        .in_data(r.rx),
        .out_valid(RD_VALID),
        .out_ready(RD_READY),
        .out_data(RD_DATA)
    );

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        n = r;
        n.push = 1'b0;
        n.sck_s1 = LINK.sck;
        n.sck_s2 = r.sck_s1;
        n.sck_p = r.sck_s2;
        n.sdo_s1 = LINK.sdo_line;
        n.sdo_s2 = r.sdo_s1;
        n.busy_s1 = LINK.busy;
        n.busy_s2 = r.busy_s1;
        n.strap_n = INT_CLK_MODE;
        n.sck_oe = ~INT_CLK_MODE;
        case (r.st)
            adcsr_pkg::HST_IDLE: begin
                n.cs_n = 1'b1;
                n.sck = 1'b0;
                // Busy low means a result waits; internal mode lets the converter pace
                if (ENABLE && fifo_ready && (INT_CLK_MODE || !r.busy_s2)) begin
                    n.cs_n = 1'b0;
                    n.tx = CFG_WORD;
                    n.sdi = CFG_WORD[12];
                    n.bits = 6'd0;
                    n.cnt = 16'd0;
                    n.st = adcsr_pkg::HST_SHIFT;
                end
            end
            adcsr_pkg::HST_SHIFT: begin
                if (!INT_CLK_MODE) begin
                    n.cnt = phase_end ? 16'd0 : r.cnt + 16'd1;
                    if (phase_hi) begin
                        n.sck = 1'b1;
                        n.rx = {r.rx[30:0], r.sdo_s2};
                        n.bits = r.bits + 6'd1;
                    end else if (phase_end) begin
                        n.sck = 1'b0;
                        n.tx = {r.tx[11:0], 1'b0};
                        n.sdi = r.tx[11];
                        if (r.bits == `ADCSR_FRAME_BITS) begin
                            // Select rises in the same cycle as the 32nd fall, well past the 14th
                            n.cs_n = 1'b1;
                            n.push = 1'b1;
                            n.cnt = 16'd0;
                            n.st = adcsr_pkg::HST_GAP;
                        end
                    end
                end else if (sck_rise) begin
                    n.rx = {r.rx[30:0], r.sdo_s2};
                    n.bits = r.bits + 6'd1;
                    if (r.bits + 6'd1 == `ADCSR_FRAME_BITS) begin
                        n.cs_n = 1'b1;
                        n.push = 1'b1;
                        n.cnt = 16'd0;
                        n.st = adcsr_pkg::HST_GAP;
                    end
                end else if (sck_fall && r.bits != 6'd0) begin // Converter drops its clock before the first rise
                    n.tx = {r.tx[11:0], 1'b0};
                    n.sdi = r.tx[11];
                end
            end
            adcsr_pkg::HST_GAP: begin
                // Select stays high long enough for busy to rise through sync
                n.cs_n = 1'b1;
                if (r.cnt == `ADCSR_GAP_CYC - 16'd1) begin
                    n.st = adcsr_pkg::HST_IDLE;
                end else begin
                    n.cnt = r.cnt + 16'd1;
                end
            end
            default: begin
                n.st = adcsr_pkg::HST_IDLE;
            end
        endcase
    end

    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            r <= '0;
            r.st <= adcsr_pkg::HST_IDLE;
            r.cs_n <= 1'b1;
            // Clock line idles high through its pull-up; a low start would fake a first rise
            r.sck_s1 <= 1'b1;
            r.sck_s2 <= 1'b1;
            r.sck_p <= 1'b1;
            r.busy_s1 <= 1'b1;
            r.busy_s2 <= 1'b1;
        end else begin
            r <= n;
        end
    end
endmodule : adcsr_host

// ### sim/adcsr_link_checker.sv
// Checker of the link that joins the converter end and the host end.
// Assumes one REF_CLK domain; inputs are the interface signals.
module adcsr_link_checker (
    input wire logic REF_CLK, // Clock
    input wire logic SRST, // Reset, high
    input wire logic cs_n, // Chip select
    input wire logic sck, // Resolved serial clock
    input wire logic sck_h_oe, // Host clock enable
    input wire logic sdo, // Data value
    input wire logic sdo_oe, // Data enable
    input wire logic busy, // Converter busy
    input wire logic clock_source_strap_n // Clock source strap
);
    timeunit 1ns;
    timeprecision 100ps;
    logic sck_q_r;
    logic [5:0] rises_r;
    logic [9:0] conv_r;
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (SRST);
    ////////////////////////////////////////
    // Rises per readout and cycles per conversion; a stuck state shows as a runaway count
    always_ff @(posedge REF_CLK) begin
        sck_q_r <= sck;
        rises_r <= (SRST || busy) ? 6'h00 : rises_r + {5'h00, sck & ~sck_q_r};
        conv_r <= (SRST || !busy) ? 10'h000 : conv_r + 10'h001;
    end
    ////////////////////////////////////////
    // Five cycles of slack cover the select synchroniser
    property p_float; cs_n [*5] |-> !sdo_oe; endproperty
    a_float: assert property (p_float) else $error("data driven while deselected");
    property p_status; sdo_oe && busy |-> sdo; endproperty
    a_status: assert property (p_status) else $error("status low while converting");
    property p_strap; !clock_source_strap_n && !cs_n |-> sck_h_oe; endproperty
    a_strap: assert property (p_strap) else $error("host clock not driven");
    property p_shift; sdo_oe && !busy && !$fell(busy) && $changed(sdo) |-> !sck; endproperty
    a_shift: assert property (p_shift) else $error("data changed with clock high");
    property p_test; $fell(busy) && clock_source_strap_n && !cs_n |=> !sck [*8] ##[30:50] sck; endproperty
    a_test: assert property (p_test) else $error("first rise off the test delay");
    property p_hold; clock_source_strap_n && rises_r == 6'h20 |-> sck; endproperty
    a_hold: assert property (p_hold) else $error("clock not held high after frame");
    property p_start; $rose(busy) |-> cs_n || rises_r == 6'h20; endproperty
    a_start: assert property (p_start) else $error("conversion began mid readout");
    property p_sleep; conv_r < 10'h190; endproperty
    a_sleep: assert property (p_sleep) else $error("conversion never ended");
    property p_frame; rises_r <= 6'h20; endproperty
    a_frame: assert property (p_frame) else $error("frame longer than 32 rises");
endmodule : adcsr_link_checker

// ### sim/testbench.sv
// Self-checking bench: converter and host ends joined on one link.
// Assumes the core files are compiled first; frames are predicted from RESULT.
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic REF_CLK = 1'b0, SRST = 1'b1, INT_CLK_MODE = 1'b0, ENABLE = 1'b0, RD_READY = 1'b0, busy_q = 1'b1;
    logic [1:0] rd_mode = 2'h0;
    logic [30:0] RESULT = 31'h439d9f41;
    logic [12:0] CFG_WORD = 13'h00a5, CFG;
    logic [31:0] RD_DATA, seed = 32'hc39d9f41;
    logic RD_VALID, MUX_SWITCH, CONVERTING;
    logic [31:0] exp_q[$];
    int mismatches = 0, checks_done = 0, frames = 0, mux_cnt = 0;
    logic prev_dbl = 1'b0;
    adcsr_if adcsr_if_i ();
    adcsr_dev adcsr_dev_i (.REF_CLK(REF_CLK), .SRST(SRST), .LINK(adcsr_if_i), .RESULT(RESULT), .CFG(CFG),
        .MUX_SWITCH(MUX_SWITCH), .CONVERTING(CONVERTING));
    adcsr_host adcsr_host_i (.REF_CLK(REF_CLK), .SRST(SRST), .LINK(adcsr_if_i), .INT_CLK_MODE(INT_CLK_MODE),
        .ENABLE(ENABLE), .CFG_WORD(CFG_WORD), .RD_DATA(RD_DATA), .RD_VALID(RD_VALID), .RD_READY(RD_READY));
    adcsr_link_checker adcsr_link_checker_i (.REF_CLK(REF_CLK), .SRST(SRST), .cs_n(adcsr_if_i.cs_n),
        .sck(adcsr_if_i.sck), .sck_h_oe(adcsr_if_i.sck_h_oe), .sdo(adcsr_if_i.sdo), .sdo_oe(adcsr_if_i.sdo_oe),
        .busy(adcsr_if_i.busy), .clock_source_strap_n(adcsr_if_i.clock_source_strap_n));
    ////////////////////////////////////////
    // 100 MHz clock
    initial begin
        forever #5 REF_CLK = ~REF_CLK;
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] v;
        v = s ^ (s << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction : xs
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : tally_and_finish
    // Steps end just after an edge so inputs never change on the sampling edge
    task automatic cyc(input int n);
        repeat (n) @(posedge REF_CLK);
        #1;
    endtask : cyc
    task automatic wait_frames(input int n);
        int goal;
        goal = frames + n;
        for (int k = 0; k < 20000 && frames < goal; k++) @(posedge REF_CLK);
        #1;
        if (frames < goal) begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, frames, goal);
            tally_and_finish();
        end
    endtask : wait_frames
    ////////////////////////////////////////
    // Each conversion start gets a fresh result; the frame it will yield is noted
    always @(posedge REF_CLK) begin
        #1;
        seed = xs(seed);
        RD_READY = rd_mode[1] | (rd_mode[0] & seed[7]);
        // Switch pulses per conversion: one at the end if double rate was in force, one at commit if not
        if (SRST) begin
            mux_cnt = 0;
            prev_dbl = 1'b0;
        end else if (MUX_SWITCH === 1'b1) begin
            mux_cnt++;
        end
        if (!SRST && adcsr_if_i.busy === 1'b1 && busy_q === 1'b0) begin
            check({19'h0, CFG}, {19'h0, CFG_WORD});
            check(32'(mux_cnt), {31'h0, prev_dbl} + {31'h0, ~CFG_WORD[0]});
            check({31'h0, CONVERTING}, 32'h1);
            prev_dbl = CFG_WORD[0];
            mux_cnt = 0;
            RESULT = seed[30:0];
            exp_q.push_back({1'b0, RESULT});
        end
        busy_q = adcsr_if_i.busy;
    end
    // Oldest note against each frame the user side accepts
    always @(posedge REF_CLK) begin
        if (RD_VALID === 1'b1 && RD_READY === 1'b1) begin
            frames++;
            check(RD_DATA, exp_q.size() > 0 ? exp_q.pop_front() : 32'hxxxxxxxx);
        end
    end
    ////////////////////////////////////////
    // Host clock with random stalls, then fill to refusal, drain, then converter clock
    initial begin
        exp_q.push_back({1'b0, RESULT});
        cyc(8);
        SRST = 1'b0;
        ENABLE = 1'b1;
        rd_mode = 2'h1;
        wait_frames(4);
        $display("test host clock frames done");
        rd_mode = 2'h0;
        cyc(10000);
        check({29'h0, RD_VALID, adcsr_if_i.busy, adcsr_if_i.sdo_oe}, 32'h4);
        rd_mode = 2'h2;
        wait_frames(8);
        ENABLE = 1'b0;
        cyc(1500);
        check({31'h0, RD_VALID}, 32'h0);
        $display("test fill and drain done");
        SRST = 1'b1;
        INT_CLK_MODE = 1'b1;
        CFG_WORD = 13'h1ffe;
        cyc(8);
        exp_q.delete();
        exp_q.push_back({1'b0, RESULT});
        SRST = 1'b0;
        ENABLE = 1'b1;
        wait_frames(4);
        $display("test converter clock frames done");
        tally_and_finish();
    end
endmodule : testbench
